// >>> hw/bose_exec.sv
// Executor for byte file ops, skip-on-zero ops and the unconditional branch
// Behaviour
// - complement file byte into chosen destination
// - destination 0 is accumulator, 1 is file
// - clear file byte, always set zero flag
// - decrement file byte into chosen destination
// - clear accumulator, set zero flag
// - decrement, skip next when zero, flags untouched
// - increment, skip next when zero, flags untouched
// - branch literal loads counter bits ten..zero
// - counter bits 14..11 from latch bits 6..3
// - branch takes two instruction cycles
`timescale 1ns/1ns
`default_nettype none
module bose_exec #(
    // Widths fixed by the instruction format
    parameter int DATA_W = bose_pkg::DATA_W,
    parameter int ADDR_W = bose_pkg::ADDR_W,
    parameter int PC_W   = bose_pkg::PC_W,
    parameter int LIT_W  = bose_pkg::LIT_W
) (
    // Clock, reset, enable
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    // Decoded instruction
    input  wire logic                 instr_valid,
    input  wire bose_pkg::bose_op_t   instr_op,
    input  wire logic [6:0]           file_addr,
    input  wire logic                 dest_sel,
    input  wire logic [10:0]          branch_literal,
    // File register read port and latch
    input  wire logic [7:0]           file_rdata,
    input  wire logic [7:0]           program_latch_high,
    // File register write port
    output logic                      file_we,
    output logic [6:0]                file_waddr,
    output logic [7:0]                file_wdata,
    // Core state
    output logic [7:0]                accumulator,
    output logic                      zero_flag,
    output logic [14:0]               program_counter,
    // Sequencing
    output logic                      instr_ready,
    output logic                      nop_cycle
);
    // ==========================================
    // Width check: port fields follow the fixed instruction format, so other sizes cannot work
    if (DATA_W != bose_pkg::DATA_W || ADDR_W != bose_pkg::ADDR_W ||
        PC_W != bose_pkg::PC_W || LIT_W != bose_pkg::LIT_W) begin : g_bad_width
        $error("bose_exec supports only the default widths");
    end

    // ==========================================
    // Arithmetic unit
    bose_alu_if alu_bus ();
    assign alu_bus.op      = instr_op;
    assign alu_bus.operand = file_rdata;
    bose_alu u_alu (.alu(alu_bus));

    // ==========================================
    // Sequencer: second cycle of skips and branches is a forced NOP
    typedef enum logic [0:0] {BOSE_ST_RUN, BOSE_ST_NOP} bose_state_t;
    bose_state_t state_reg, state_next;

    logic        take;
    logic [7:0]  acc_reg, acc_next;
    logic        zero_reg, zero_next;
    logic [14:0] pc_reg, pc_next;
    logic        we_reg, we_next;
    logic [6:0]  waddr_reg, waddr_next;
    logic [7:0]  wdata_reg, wdata_next;

    assign instr_ready = (state_reg == BOSE_ST_RUN);
    assign take        = clk_en && instr_valid && instr_ready;

    always_comb begin
        state_next = state_reg;
        acc_next   = acc_reg;
        zero_next  = zero_reg;
        pc_next    = pc_reg;
        we_next    = 1'b0;
        waddr_next = file_addr;
        wdata_next = alu_bus.result;
        case (state_reg)
            BOSE_ST_RUN: begin
                if (take) begin
                    pc_next = pc_reg + 15'h0001;
                    case (instr_op)
                        bose_pkg::BOSE_OP_COMPLEMENT,
                        bose_pkg::BOSE_OP_DECREMENT,
                        bose_pkg::BOSE_OP_DEC_SKIP,
                        bose_pkg::BOSE_OP_INC_SKIP: begin
                            if (dest_sel == bose_pkg::DEST_FILE) begin
                                we_next = 1'b1;
                            end else begin
                                acc_next = alu_bus.result;
                            end
                            if (instr_op == bose_pkg::BOSE_OP_COMPLEMENT ||
                                instr_op == bose_pkg::BOSE_OP_DECREMENT) begin
                                zero_next = alu_bus.result_zero;
                            end else if (alu_bus.result_zero) begin
                                state_next = BOSE_ST_NOP;
                            end
                        end
                        bose_pkg::BOSE_OP_CLEAR_FILE: begin
                            we_next   = 1'b1;
                            zero_next = 1'b1;
                        end
                        bose_pkg::BOSE_OP_CLEAR_ACC: begin
                            acc_next  = bose_pkg::ZERO_BYTE;
                            zero_next = 1'b1;
                        end
                        bose_pkg::BOSE_OP_BRANCH: begin
                            pc_next = {program_latch_high[bose_pkg::LATCH_HI:bose_pkg::LATCH_LO],
                                       branch_literal};
                            state_next = BOSE_ST_NOP;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            BOSE_ST_NOP: begin
                // Fetched word is discarded; only the counter moves on
                if (clk_en) begin
                    pc_next    = pc_reg + 15'h0001;
                    state_next = BOSE_ST_RUN;
                end
            end
            default: state_next = BOSE_ST_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= BOSE_ST_RUN;
            acc_reg   <= bose_pkg::ZERO_BYTE;
            zero_reg  <= 1'b0;
            pc_reg    <= bose_pkg::PC_RESET;
            we_reg    <= 1'b0;
            waddr_reg <= 7'h00;
            wdata_reg <= bose_pkg::ZERO_BYTE;
        end else if (clk_en) begin
            state_reg <= state_next;
            acc_reg   <= acc_next;
            zero_reg  <= zero_next;
            pc_reg    <= pc_next;
            we_reg    <= we_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
        end
    end

    assign file_we         = we_reg;
    assign file_waddr      = waddr_reg;
    assign file_wdata      = wdata_reg;
    assign accumulator     = acc_reg;
    assign zero_flag       = zero_reg;
    assign program_counter = pc_reg;
    assign nop_cycle       = (state_reg == BOSE_ST_NOP);

    // ==========================================
    // Checks
    sequence take_op(bose_pkg::bose_op_t o);
        clk_en && take && instr_op == o;
    endsequence

    sequence take_op_to(bose_pkg::bose_op_t o, logic d);
        clk_en && take && instr_op == o && dest_sel == d;
    endsequence

    // Forced NOP cycle that the enable lets through
    sequence forced_nop;
        clk_en && nop_cycle;
    endsequence

    complement_result_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op_to(bose_pkg::BOSE_OP_COMPLEMENT, bose_pkg::DEST_FILE) |=>
            file_we && file_wdata == ~$past(file_rdata))
        else $error("complement result wrong");
    complement_acc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op_to(bose_pkg::BOSE_OP_COMPLEMENT, bose_pkg::DEST_ACC) |=>
            !file_we && accumulator == ~$past(file_rdata))
        else $error("complement into accumulator wrong");
    dest_acc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take && dest_sel == bose_pkg::DEST_ACC && instr_op != bose_pkg::BOSE_OP_CLEAR_FILE |=> !file_we)
        else $error("accumulator destination wrote file");
    clear_file_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op(bose_pkg::BOSE_OP_CLEAR_FILE) |=> file_we && file_wdata == 8'h00 && zero_flag)
        else $error("clear file wrong");
    decrement_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op(bose_pkg::BOSE_OP_DECREMENT) |=> zero_flag == ($past(file_rdata) == 8'h01))
        else $error("decrement zero flag wrong");
    decrement_file_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op_to(bose_pkg::BOSE_OP_DECREMENT, bose_pkg::DEST_FILE) |=>
            file_we && file_waddr == $past(file_addr) && file_wdata == 8'($past(file_rdata) - 8'h01))
        else $error("decrement write back wrong");
    clear_acc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op(bose_pkg::BOSE_OP_CLEAR_ACC) |=> accumulator == 8'h00 && zero_flag)
        else $error("clear accumulator wrong");
    dec_skip_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op(bose_pkg::BOSE_OP_DEC_SKIP) |=> $stable(zero_flag) && (nop_cycle == ($past(file_rdata) == 8'h01)))
        else $error("decrement skip wrong");
    inc_skip_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op(bose_pkg::BOSE_OP_INC_SKIP) |=> $stable(zero_flag) && (nop_cycle == ($past(file_rdata) == 8'hff)))
        else $error("increment skip wrong");
    branch_target_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op(bose_pkg::BOSE_OP_BRANCH) |=>
            program_counter == {$past(program_latch_high[6:3]), $past(branch_literal)})
        else $error("branch target wrong");
    branch_two_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op(bose_pkg::BOSE_OP_BRANCH) ##1 clk_en |=> !nop_cycle)
        else $error("branch not two cycles");
    inc_skip_acc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op_to(bose_pkg::BOSE_OP_INC_SKIP, bose_pkg::DEST_ACC) |=>
            accumulator == 8'($past(file_rdata) + 8'h01))
        else $error("increment skip result wrong");
    branch_nop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        take_op(bose_pkg::BOSE_OP_BRANCH) |=> nop_cycle && !instr_ready)
        else $error("branch second cycle missing");
    nop_discard_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        forced_nop |=> !file_we && program_counter == 15'($past(program_counter) + 15'h0001))
        else $error("forced nop did work");
    // A frozen cycle must leave the counter, accumulator, zero flag, write enable and NOP state alone
    enable_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clk_en |=> $stable(program_counter) && $stable(accumulator) && $stable(zero_flag) &&
            $stable(file_we) && $stable(nop_cycle))
        else $error("state moved with enable low");
endmodule // bose_exec
`default_nettype wire

// >>> include/bose_pkg.sv
// Package: opcodes, widths and cycle counts for the byte-op / skip / branch executor
package bose_pkg;
    // ==========================================
    // Widths
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 7;
    localparam int PC_W     = 15;
    localparam int LIT_W    = 11;
    // ==========================================
    // Field positions
    localparam int LATCH_LO = 3;
    localparam int LATCH_HI = 6;
    // ==========================================
    // Reset values and counts
    localparam logic [7:0]  ZERO_BYTE    = 8'h00;
    localparam logic [14:0] PC_RESET     = 15'h0000;
    localparam logic [1:0]  SKIP_CYCLES  = 2'h2;
    localparam logic [1:0]  BRANCH_CYCLES = 2'h2;
    // ==========================================
    // Operations
    typedef enum logic [2:0] {
        BOSE_OP_NONE,
        BOSE_OP_COMPLEMENT,
        BOSE_OP_CLEAR_FILE,
        BOSE_OP_DECREMENT,
        BOSE_OP_CLEAR_ACC,
        BOSE_OP_DEC_SKIP,
        BOSE_OP_INC_SKIP,
        BOSE_OP_BRANCH
    } bose_op_t;
    // Destination bit encoding
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;
endpackage

// >>> include/bose_alu_if.sv
// Interface: operands and results between the executor and its byte arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface bose_alu_if;
    bose_pkg::bose_op_t op;
    logic [7:0]         operand;
    logic [7:0]         result;
    logic               result_zero;
    modport exec (output op, output operand, input result, input result_zero);
    modport alu  (input op, input operand, output result, output result_zero);
endinterface
`default_nettype wire

// >>> hw/bose_alu.sv
// Byte arithmetic unit: complement, clear, decrement, increment
`timescale 1ns/1ns
`default_nettype none
module bose_alu (
    // Operands from and results to the executor
    bose_alu_if.alu alu
);
    always_comb begin
        case (alu.op)
            bose_pkg::BOSE_OP_COMPLEMENT: alu.result = ~alu.operand;
            bose_pkg::BOSE_OP_CLEAR_FILE,
            bose_pkg::BOSE_OP_CLEAR_ACC:  alu.result = bose_pkg::ZERO_BYTE;
            bose_pkg::BOSE_OP_DECREMENT,
            bose_pkg::BOSE_OP_DEC_SKIP:   alu.result = alu.operand - 8'h01;
            bose_pkg::BOSE_OP_INC_SKIP:   alu.result = alu.operand + 8'h01;
            default:                      alu.result = alu.operand;
        endcase
        alu.result_zero = (alu.result == bose_pkg::ZERO_BYTE);
    end
endmodule // bose_alu
`default_nettype wire

// >>> tb/bose_exec_test.sv
// Testbench: self-checking run of the byte-op, skip-on-zero and branch executor
`timescale 1ns/1ns
`default_nettype none
module bose_exec_test;
    typedef struct packed {
        bose_pkg::bose_op_t op;
        logic               d;
        logic [6:0]         a;
        logic [7:0]         r;
        logic [10:0]        k;
        logic [7:0]         l;
        logic [7:0]         res;
        logic               we;
        logic [7:0]         acc;
        logic               z;
        logic               n;
    } bose_row_t;
    localparam bose_pkg::bose_op_t op_no = bose_pkg::BOSE_OP_NONE;
    localparam bose_pkg::bose_op_t op_cp = bose_pkg::BOSE_OP_COMPLEMENT;
    localparam bose_pkg::bose_op_t op_cf = bose_pkg::BOSE_OP_CLEAR_FILE;
    localparam bose_pkg::bose_op_t op_dc = bose_pkg::BOSE_OP_DECREMENT;
    localparam bose_pkg::bose_op_t op_ca = bose_pkg::BOSE_OP_CLEAR_ACC;
    localparam bose_pkg::bose_op_t op_ds = bose_pkg::BOSE_OP_DEC_SKIP;
    localparam bose_pkg::bose_op_t op_is = bose_pkg::BOSE_OP_INC_SKIP;
    localparam bose_pkg::bose_op_t op_br = bose_pkg::BOSE_OP_BRANCH;
    logic               core_clk           = 1'b0;
    logic               sys_rst            = 1'b1;
    logic               clk_en             = 1'b1;
    logic               instr_valid        = 1'b0;
    bose_pkg::bose_op_t instr_op           = op_no;
    logic [6:0]         file_addr          = 7'h00;
    logic               dest_sel           = 1'b0;
    logic [10:0]        branch_literal     = 11'h000;
    logic [7:0]         file_rdata         = 8'h00;
    logic [7:0]         program_latch_high = 8'h00;
    logic               file_we;
    logic [6:0]         file_waddr;
    logic [7:0]         file_wdata;
    logic [7:0]         accumulator;
    logic               zero_flag;
    logic [14:0]        program_counter;
    logic               instr_ready;
    logic               nop_cycle;
    int                 err_count          = 0;
    int                 num_checks         = 0;
    int                 cycles             = 0;
    logic [14:0]        pc_exp;
    bose_row_t          rows [16];

    bose_exec i_bose_exec (.core_clk, .sys_rst, .clk_en, .instr_valid, .instr_op, .file_addr, .dest_sel,
        .branch_literal, .file_rdata, .program_latch_high, .file_we, .file_waddr, .file_wdata,
        .accumulator, .zero_flag, .program_counter, .instr_ready, .nop_cycle);

    always #5 core_clk = ~core_clk;

    // Whole run is well under 300 cycles, so this only trips on a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 600) begin
            err_count++;
            finish_test();
        end
    end

    task finish_test();
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task check(input logic [14:0] seen, input logic [14:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task drive(input bose_row_t r);
        instr_valid = 1'b1;
        instr_op = r.op;
        dest_sel = r.d;
        file_addr = r.a;
        file_rdata = r.r;
        branch_literal = r.k;
        program_latch_high = r.l;
    endtask

    task check_reset();
        check(program_counter, bose_pkg::PC_RESET);
        check(15'({accumulator, zero_flag, file_we, nop_cycle, instr_ready}), 15'h0001);
    endtask

    initial begin
        // Dest 0 on the file clear and 1 on the accumulator clear must not matter
        rows[0]  = {op_cp, 1'b1, 7'h7f, 8'h5a, 11'h000, 8'h00, 8'ha5, 1'b1, 8'h00, 1'b0, 1'b0};
        rows[1]  = {op_cp, 1'b0, 7'h00, 8'hf0, 11'h000, 8'h00, 8'h0f, 1'b0, 8'h0f, 1'b0, 1'b0};
        rows[2]  = {op_dc, 1'b1, 7'h01, 8'h01, 11'h000, 8'h00, 8'h00, 1'b1, 8'h0f, 1'b1, 1'b0};
        rows[3]  = {op_dc, 1'b0, 7'h02, 8'h00, 11'h000, 8'h00, 8'hff, 1'b0, 8'hff, 1'b0, 1'b0};
        rows[4]  = {op_cf, 1'b0, 7'h03, 8'h3c, 11'h000, 8'h00, 8'h00, 1'b1, 8'hff, 1'b1, 1'b0};
        rows[5]  = {op_cp, 1'b0, 7'h04, 8'hfe, 11'h000, 8'h00, 8'h01, 1'b0, 8'h01, 1'b0, 1'b0};
        rows[6]  = {op_ca, 1'b1, 7'h05, 8'h77, 11'h000, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0};
        rows[7]  = {op_cp, 1'b0, 7'h06, 8'h55, 11'h000, 8'h00, 8'haa, 1'b0, 8'haa, 1'b0, 1'b0};
        rows[8]  = {op_ds, 1'b1, 7'h07, 8'h01, 11'h000, 8'h00, 8'h00, 1'b1, 8'haa, 1'b0, 1'b1};
        rows[9]  = {op_ds, 1'b0, 7'h08, 8'h05, 11'h000, 8'h00, 8'h04, 1'b0, 8'h04, 1'b0, 1'b0};
        rows[10] = {op_is, 1'b0, 7'h09, 8'hff, 11'h000, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1};
        rows[11] = {op_cp, 1'b0, 7'h0a, 8'hff, 11'h000, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0};
        rows[12] = {op_is, 1'b1, 7'h0b, 8'h7f, 11'h000, 8'h00, 8'h80, 1'b1, 8'h00, 1'b1, 1'b0};
        rows[13] = {op_br, 1'b1, 7'h0c, 8'h00, 11'h7ff, 8'h78, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1};
        rows[14] = {op_br, 1'b1, 7'h0d, 8'h00, 11'h000, 8'h87, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1};
        rows[15] = {op_no, 1'b1, 7'h0e, 8'h00, 11'h000, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0};
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        pc_exp = bose_pkg::PC_RESET;
        check_reset();
        drive(rows[0]);
        // Rows run back to back; a row after a forced NOP is held, refused, then taken
        for (int i = 0; i < 16; i++) begin
            @(negedge core_clk);
            pc_exp = (rows[i].op == op_br) ? {rows[i].l[6:3], rows[i].k} : pc_exp + 15'h0001;
            check(15'(file_we), 15'(rows[i].we));
            if (rows[i].we) check(15'({file_waddr, file_wdata}), 15'({rows[i].a, rows[i].res}));
            check(15'(accumulator), 15'(rows[i].acc));
            check(15'(zero_flag), 15'(rows[i].z));
            check(program_counter, pc_exp);
            check(15'({nop_cycle, instr_ready}), 15'({rows[i].n, ~rows[i].n}));
            if (i < 15) drive(rows[i + 1]);
            else begin
                clk_en = 1'b0;
                instr_op = op_dc;
                dest_sel = 1'b0;
                file_rdata = 8'h10;
            end
            if (rows[i].n) begin
                @(negedge core_clk);
                pc_exp = pc_exp + 15'h0001;
                check(15'({file_we, nop_cycle, instr_ready}), 15'h0001);
                check(program_counter, pc_exp);
            end
        end
        // Enable low: the pending decrement must wait
        @(negedge core_clk);
        check(program_counter, pc_exp);
        check(15'({accumulator, file_we}), 15'h0000);
        clk_en = 1'b1;
        @(negedge core_clk);
        check(15'({accumulator, zero_flag}), 15'h001e);
        check(program_counter, pc_exp + 15'h0001);
        instr_op = op_br;
        branch_literal = 11'h123;
        program_latch_high = 8'h28;
        @(negedge core_clk);
        check(program_counter, 15'h2923);
        check(15'(nop_cycle), 15'h0001);
        // Reset landing in the forced NOP cycle must clear it
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        @(negedge core_clk);
        check_reset();
        sys_rst = 1'b0;
        finish_test();
    end
endmodule // bose_exec_test
`default_nettype wire
